// ### i2c_wiper_slave.sv
// Serial two-wire slave holding the seven-bit volatile wiper register
// Functional notes
// (R1) Data falling while clock high starts
// (R2) Data changes only while clock low
// (R3) Acknowledge accepted byte on ninth clock
// (R4) Mismatched address gets not-acknowledge
// (R5) Master restarts after any error
// (R6) General call is not acknowledged
// (R7) Collision resets the serial logic
// (R8) Data rising while clock high stops
// (R9) Clock line is never held low
// (R10) Malformed frames abort, wiper untouched
// (R11) Undefined command: ignore until valid start
// (R12) Fixed address 0101111 only
// (R13) Master recovery: start, nine ones, start, stop
// (R14) Master not-acknowledge releases bus, resets
// (R15) Write: address with write bit, data
// (R16) Byte stored at its acknowledge only
// (R17) Any number of bytes per write
// (R18) Top data bit ignored on write
// (R19) Read: address with read bit, data
// (R20) Master not-acknowledges final read byte
// (R21) Read drives eight bits, MSB first
// (R22) Clock and data pass spike filter
// (R23) Reset loads mid-scale wiper value
// (R24) Single wiper register, no sub-address
// (R25) Read byte is zero then wiper
`include "i2c_wiper_defs.svh"
module i2c_wiper_slave #(
   parameter int SPIKE_CYC = `WIPER_SPIKE_CYC
) (
   input wire logic ref_clk_in,
   input wire logic rst_b_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic scl_out_out,
   output logic scl_oe_out,
   output logic sda_out_out,
   output logic sda_oe_out,
   output logic [6:0] wiper_out
);
   localparam i2c_wiper_pkg::core_s CORE_RST = '{
      st: i2c_wiper_pkg::ST_IDLE, wiper: `WIPER_RESET_VAL, default: '0};

   pin_level_if p ();

   i2c_wiper_pkg::core_s r;
   i2c_wiper_pkg::core_s n;
   logic start;
   logic stop;

   pin_glitch_filter #(
      .SPIKE_CYC(SPIKE_CYC)
   ) u_filt (
      .ref_clk_in(ref_clk_in),
      .rst_b_in(rst_b_in),
      .scl_pin_in(scl_in),
      .sda_pin_in(sda_in),
      .lvl_if(p.src)
   );

   function automatic logic addr_hit(input logic [7:0] b);
      return b[7:1] == `WIPER_SLAVE_ADDR;
   endfunction

   function automatic logic [7:0] shift_in(input logic [7:0] b, input logic d);
      return {b[6:0], d};
   endfunction

   // Our own drive is read back through sda_in, so start and stop can
   // only be seen while the data line is released.
   assign start = p.sda_fall & p.scl_lvl; // R1
   assign stop = p.sda_rise & p.scl_lvl; // R8

   always_comb begin
      n = r;
      n.scl_oe = 1'b0; // R9
      n.zero = 1'b0;
      if (start) begin
         // Any start aborts the frame; a partial byte is dropped
         n.st = i2c_wiper_pkg::ST_ADDR; // R1 R5 R10 R16
         n.cnt = 4'h0;
         n.ack = 1'b0;
         n.sda_oe = 1'b0;
      end else if (stop) begin
         n.st = i2c_wiper_pkg::ST_IDLE; // R8 R10 R16
         n.cnt = 4'h0;
         n.ack = 1'b0;
         n.sda_oe = 1'b0;
      end else begin
         case (r.st)
            i2c_wiper_pkg::ST_ADDR: begin
               if (p.scl_rise) begin
                  n.shf = shift_in(r.shf, p.sda_lvl);
                  n.cnt = r.cnt + 4'h1;
               end else if (p.scl_fall && r.cnt == `WIPER_BYTE_BITS) begin
                  if (addr_hit(r.shf)) begin
                     n.rw = r.shf[`WIPER_RW_POS]; // R12
                     n.sda_oe = 1'b1; // R3
                     n.st = i2c_wiper_pkg::ST_ADDR_ACK;
                  end else begin
                     // General call and foreign addresses fall off the bus
                     n.sda_oe = 1'b0; // R4 R6
                     n.st = i2c_wiper_pkg::ST_IGNORE; // R11
                  end
               end
            end
            i2c_wiper_pkg::ST_ADDR_ACK: begin
               if (p.scl_fall) begin
                  n.cnt = 4'h0;
                  if (r.rw) begin
                     n.shf = {1'b0, r.wiper}; // R25
                     n.sda_oe = 1'b1; // R21
                     n.st = i2c_wiper_pkg::ST_RD_DATA; // R19
                  end else begin
                     n.sda_oe = 1'b0;
                     n.st = i2c_wiper_pkg::ST_WR_DATA; // R15
                  end
               end
            end
            i2c_wiper_pkg::ST_WR_DATA: begin
               if (p.scl_rise) begin
                  n.shf = shift_in(r.shf, p.sda_lvl);
                  n.cnt = r.cnt + 4'h1;
               end else if (p.scl_fall && r.cnt == `WIPER_BYTE_BITS) begin
                  n.sda_oe = 1'b1; // R3
                  n.st = i2c_wiper_pkg::ST_WR_ACK;
               end
            end
            i2c_wiper_pkg::ST_WR_ACK: begin
               if (p.scl_rise) begin
                  // Stored mid-acknowledge, so a late abort cannot tear it
                  n.wiper = r.shf[6:0]; // R16 R18 R24
               end else if (p.scl_fall) begin
                  n.sda_oe = 1'b0;
                  n.cnt = 4'h0;
                  n.st = i2c_wiper_pkg::ST_WR_DATA; // R17
               end
            end
            i2c_wiper_pkg::ST_RD_DATA: begin
               if (p.scl_rise) begin
                  if (!r.sda_oe && !p.sda_lvl) begin
                     // Released a one but the bus reads zero
                     n.st = i2c_wiper_pkg::ST_IDLE; // R7
                     n.cnt = 4'h0;
                  end else begin
                     n.cnt = r.cnt + 4'h1;
                  end
               end else if (p.scl_fall) begin
                  if (r.cnt == `WIPER_BYTE_BITS) begin
                     n.sda_oe = 1'b0; // R21
                     n.ack = 1'b0;
                     n.st = i2c_wiper_pkg::ST_RD_ACK;
                  end else begin
                     n.shf = {r.shf[6:0], 1'b0};
                     n.sda_oe = ~r.shf[6]; // R21
                  end
               end
            end
            i2c_wiper_pkg::ST_RD_ACK: begin
               if (p.scl_rise) begin
                  if (p.sda_lvl) begin
                     // Master ends the read or forces recovery
                     n.st = i2c_wiper_pkg::ST_IGNORE; // R14 R20 R13
                  end else begin
                     n.ack = 1'b1;
                  end
               end else if (p.scl_fall && r.ack) begin
                  n.ack = 1'b0;
                  n.cnt = 4'h0;
                  n.shf = {1'b0, r.wiper}; // R25
                  n.sda_oe = 1'b1;
                  n.st = i2c_wiper_pkg::ST_RD_DATA;
               end
            end
            i2c_wiper_pkg::ST_IGNORE: begin
               n.sda_oe = 1'b0; // R11
            end
            default: begin
               n.sda_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         r <= CORE_RST; // R23
      end else begin
         r <= n;
      end
   end

   assign scl_out_out = r.zero;
   assign scl_oe_out = r.scl_oe;
   assign sda_out_out = r.zero;
   assign sda_oe_out = r.sda_oe;
   assign wiper_out = r.wiper;

   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_b_in);

   sequence s_quiet;
      !start && !stop;
   endsequence

   sequence s_addr_done;
      r.st == i2c_wiper_pkg::ST_ADDR && r.cnt == `WIPER_BYTE_BITS && p.scl_fall
         && !start && !stop;
   endsequence

   sequence s_wr_latch;
      r.st == i2c_wiper_pkg::ST_WR_ACK && p.scl_rise && !start && !stop;
   endsequence

   property p_start_addr;
      start |=> r.st == i2c_wiper_pkg::ST_ADDR && r.cnt == 4'h0 && !r.sda_oe;
   endproperty
   a_start_addr: assert property (p_start_addr) else $error("start not taken"); // R1

   property p_stop_idle;
      stop && !start |=> r.st == i2c_wiper_pkg::ST_IDLE && !sda_oe_out;
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("stop not taken"); // R8

   property p_ack_hit;
      s_addr_done ##0 addr_hit(r.shf) |=>
         sda_oe_out && r.st == i2c_wiper_pkg::ST_ADDR_ACK;
   endproperty
   a_ack_hit: assert property (p_ack_hit) else $error("own address not acknowledged"); // R3

   property p_nack_miss;
      s_addr_done ##0 !addr_hit(r.shf) |=>
         !sda_oe_out && r.st == i2c_wiper_pkg::ST_IGNORE;
   endproperty
   a_nack_miss: assert property (p_nack_miss) else $error("foreign address acknowledged"); // R4

   property p_gcall;
      s_addr_done ##0 r.shf[7:1] == `WIPER_GCALL_ADDR |=> !sda_oe_out [*2];
   endproperty
   a_gcall: assert property (p_gcall) else $error("general call acknowledged"); // R6

   property p_no_stretch;
      1'b1 |-> !scl_oe_out;
   endproperty
   a_no_stretch: assert property (p_no_stretch) else $error("clock line driven"); // R9

   property p_write_ack;
      s_wr_latch |=> wiper_out == $past(r.shf[6:0]);
   endproperty
   a_write_ack: assert property (p_write_ack) else $error("wiper not loaded at ack"); // R16

   property p_wiper_src;
      $changed(wiper_out) |-> $past(r.st) == i2c_wiper_pkg::ST_WR_ACK
         && $past(p.scl_rise);
   endproperty
   a_wiper_src: assert property (p_wiper_src) else $error("wiper changed outside ack"); // R10

   property p_rd_first;
      r.st == i2c_wiper_pkg::ST_ADDR_ACK && r.rw && p.scl_fall ##0 s_quiet |=>
         sda_oe_out && r.shf == {1'b0, wiper_out};
   endproperty
   a_rd_first: assert property (p_rd_first) else $error("read byte not zero then wiper"); // R25

   property p_rd_release;
      r.st == i2c_wiper_pkg::ST_RD_DATA && r.cnt == `WIPER_BYTE_BITS && p.scl_fall
         ##0 s_quiet |=> !sda_oe_out && r.st == i2c_wiper_pkg::ST_RD_ACK;
   endproperty
   a_rd_release: assert property (p_rd_release) else $error("bus held after eight bits"); // R21

   property p_rd_shift;
      r.st == i2c_wiper_pkg::ST_RD_DATA && r.cnt != `WIPER_BYTE_BITS && p.scl_fall
         ##0 s_quiet |=> sda_oe_out == !$past(r.shf[6]);
   endproperty
   a_rd_shift: assert property (p_rd_shift) else $error("read bit order wrong"); // R21

   property p_data_ack;
      r.st == i2c_wiper_pkg::ST_WR_DATA && r.cnt == `WIPER_BYTE_BITS && p.scl_fall
         ##0 s_quiet |=> sda_oe_out && r.st == i2c_wiper_pkg::ST_WR_ACK;
   endproperty
   a_data_ack: assert property (p_data_ack) else $error("data byte not acknowledged"); // R3

   property p_wr_ack_end;
      r.st == i2c_wiper_pkg::ST_WR_ACK && p.scl_fall ##0 s_quiet |=>
         !sda_oe_out && r.st == i2c_wiper_pkg::ST_WR_DATA && r.cnt == 4'h0;
   endproperty
   a_wr_ack_end: assert property (p_wr_ack_end) else $error("next write byte not opened"); // R17

   property p_nack_reset;
      r.st == i2c_wiper_pkg::ST_RD_ACK && p.scl_rise && p.sda_lvl ##0 s_quiet |=>
         r.st == i2c_wiper_pkg::ST_IGNORE && !sda_oe_out;
   endproperty
   a_nack_reset: assert property (p_nack_reset) else $error("master nack not honoured"); // R14

   property p_collide;
      r.st == i2c_wiper_pkg::ST_RD_DATA && !r.sda_oe && p.scl_rise && !p.sda_lvl
         ##0 s_quiet |=> r.st == i2c_wiper_pkg::ST_IDLE;
   endproperty
   a_collide: assert property (p_collide) else $error("collision not reset"); // R7

   // A stop drops to idle, which ignores the bus just the same
   property p_ignore;
      r.st == i2c_wiper_pkg::ST_IGNORE ##0 s_quiet |=>
         r.st == i2c_wiper_pkg::ST_IGNORE && !sda_oe_out;
   endproperty
   a_ignore: assert property (p_ignore) else $error("ignore state left early"); // R11

   property p_sda_moves;
      $changed(sda_oe_out) |-> $past(p.scl_fall) || $past(start) || $past(stop);
   endproperty
   a_sda_moves: assert property (p_sda_moves) else $error("data moved while clock high"); // R2

   property p_reset_mid;
      disable iff (1'b0)
      !rst_b_in |=> wiper_out == `WIPER_RESET_VAL && !sda_oe_out;
   endproperty
   a_reset_mid: assert property (p_reset_mid) else $error("reset value wrong"); // R23
endmodule

// ### i2c_wiper_defs.svh
// Constants of the serial wiper slave
`ifndef I2C_WIPER_DEFS_SVH
`define I2C_WIPER_DEFS_SVH
`define WIPER_SLAVE_ADDR 7'h2F
`define WIPER_GCALL_ADDR 7'h00
`define WIPER_RESET_VAL 7'h3F
`define WIPER_BYTE_BITS 4'h8
`define WIPER_RW_POS 0
`define WIPER_CLK_MHZ 20
`define WIPER_SPIKE_NS 50
`define WIPER_SPIKE_CYC ((`WIPER_SPIKE_NS * `WIPER_CLK_MHZ + 999) / 1000)
`endif

// ### i2c_wiper_pkg.sv
// Types of the serial wiper slave
package i2c_wiper_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_WR_DATA,
      ST_WR_ACK,
      ST_RD_DATA,
      ST_RD_ACK,
      ST_IGNORE
   } link_state_e;

   typedef logic [3:0] spike_cnt_t;

   typedef struct packed {
      link_state_e st;
      logic [3:0] cnt;
      logic [7:0] shf;
      logic rw;
      logic ack;
      logic sda_oe;
      logic scl_oe;
      logic zero;
      logic [6:0] wiper;
   } core_s;

   typedef struct packed {
      logic [2:0] scl_sy;
      logic [2:0] sda_sy;
      logic scl_lvl;
      logic sda_lvl;
      spike_cnt_t scl_cnt;
      spike_cnt_t sda_cnt;
      logic scl_rise;
      logic scl_fall;
      logic sda_rise;
      logic sda_fall;
   } filt_s;
endpackage

// ### pin_level_if.sv
// Filtered bus levels and edges passed from the pin filter to the core
interface pin_level_if;
   logic scl_lvl;
   logic sda_lvl;
   logic scl_rise;
   logic scl_fall;
   logic sda_rise;
   logic sda_fall;
   modport src (
      output scl_lvl,
      output sda_lvl,
      output scl_rise,
      output scl_fall,
      output sda_rise,
      output sda_fall
   );
   modport dst (
      input scl_lvl,
      input sda_lvl,
      input scl_rise,
      input scl_fall,
      input sda_rise,
      input sda_fall
   );
endinterface

// ### pin_glitch_filter.sv
// Synchroniser and spike filter for the clock and data pins
`include "i2c_wiper_defs.svh"
module pin_glitch_filter #(
   parameter int SPIKE_CYC = `WIPER_SPIKE_CYC
) (
   input wire logic ref_clk_in,
   input wire logic rst_b_in,
   input wire logic scl_pin_in,
   input wire logic sda_pin_in,
   pin_level_if.src lvl_if
);
   localparam i2c_wiper_pkg::filt_s FILT_RST = '{
      scl_sy: 3'h7, sda_sy: 3'h7, scl_lvl: 1'b1, sda_lvl: 1'b1, default: '0};

   i2c_wiper_pkg::filt_s r;
   i2c_wiper_pkg::filt_s n;

   if (SPIKE_CYC < 1 || SPIKE_CYC > 15) begin : g_bad
      $error("SPIKE_CYC must lie in 1..15");
   end

   // New level only after the agreeing stages held it long enough
   function automatic logic [4:0] filt_step(
      input logic s2,
      input logic s3,
      input logic lvl,
      input i2c_wiper_pkg::spike_cnt_t cnt
   );
      logic [4:0] res;
      res = {lvl, 4'h0};
      if (s2 == s3 && s3 != lvl) begin
         if (int'(cnt) + 1 >= SPIKE_CYC) begin
            res = {s3, 4'h0};
         end else begin
            res = {lvl, cnt + 4'h1};
         end
      end
      return res;
   endfunction

   always_comb begin
      n = r;
      n.scl_sy = {r.scl_sy[1:0], scl_pin_in};
      n.sda_sy = {r.sda_sy[1:0], sda_pin_in};
      {n.scl_lvl, n.scl_cnt} = filt_step(r.scl_sy[1], r.scl_sy[2], r.scl_lvl, r.scl_cnt); // R22
      {n.sda_lvl, n.sda_cnt} = filt_step(r.sda_sy[1], r.sda_sy[2], r.sda_lvl, r.sda_cnt); // R22
      n.scl_rise = n.scl_lvl & ~r.scl_lvl;
      n.scl_fall = ~n.scl_lvl & r.scl_lvl;
      n.sda_rise = n.sda_lvl & ~r.sda_lvl;
      n.sda_fall = ~n.sda_lvl & r.sda_lvl;
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         r <= FILT_RST;
      end else begin
         r <= n;
      end
   end

   assign lvl_if.scl_lvl = r.scl_lvl;
   assign lvl_if.sda_lvl = r.sda_lvl;
   assign lvl_if.scl_rise = r.scl_rise;
   assign lvl_if.scl_fall = r.scl_fall;
   assign lvl_if.sda_rise = r.sda_rise;
   assign lvl_if.sda_fall = r.sda_fall;

   property p_scl_agree;
      @(posedge ref_clk_in) disable iff (!rst_b_in)
      $changed(r.scl_lvl) |-> $past(r.scl_sy[2]) == r.scl_lvl
         && $past(r.scl_sy[1]) == r.scl_lvl;
   endproperty
   a_scl_agree: assert property (p_scl_agree) else $error("scl level moved without agreement"); // R22

   property p_sda_agree;
      @(posedge ref_clk_in) disable iff (!rst_b_in)
      $changed(r.sda_lvl) |-> $past(r.sda_sy[2]) == r.sda_lvl
         && $past(r.sda_sy[1]) == r.sda_lvl;
   endproperty
   a_sda_agree: assert property (p_sda_agree) else $error("sda level moved without agreement"); // R22
endmodule

// ### i2c_master_model.sv
// Behavioural two-wire bus master that drives the wiper slave
module i2c_master_model (
   input wire logic clk_in,
   input wire logic sda_in,
   output logic scl_low_out,
   output logic sda_low_out
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      scl_low_out = 1'b0;
      sda_low_out = 1'b0;
   end

   task automatic wait_cyc(input int n);
      repeat (n) @(negedge clk_in);
   endtask

   // 400 ns bit: 300 ns low so the slave's late data change lands first
   task automatic clock_bit(input logic drive_low, output logic seen);
      wait_cyc(5);
      sda_low_out = drive_low;
      wait_cyc(1);
      scl_low_out = 1'b0;
      wait_cyc(1);
      seen = sda_in;
      wait_cyc(1);
      scl_low_out = 1'b1;
   endtask

   // Works from idle or, as a repeated start, from a clock low phase
   task automatic start();
      if (scl_low_out) begin
         wait_cyc(6);
         sda_low_out = 1'b0;
         wait_cyc(4);
         scl_low_out = 1'b0;
         wait_cyc(4);
      end
      sda_low_out = 1'b1;
      wait_cyc(4);
      scl_low_out = 1'b1;
   endtask

   task automatic stop();
      wait_cyc(6);
      sda_low_out = 1'b1;
      wait_cyc(4);
      scl_low_out = 1'b0;
      wait_cyc(4);
      sda_low_out = 1'b0;
      wait_cyc(6);
   endtask

   task automatic put_bits(input logic [7:0] b, input int n);
      logic s;
      for (int i = 7; i > 7 - n; i--) begin
         clock_bit(!b[i], s);
      end
   endtask

   task automatic put_byte(input logic [7:0] b, output logic acked);
      logic s;
      put_bits(b, 8);
      clock_bit(1'b0, s);
      acked = !s;
   endtask

   task automatic get_byte(input logic [7:0] low_mask, input logic ack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clock_bit(low_mask[i], s);
         d[i] = s;
      end
      clock_bit(ack, s);
   endtask

   task automatic recover();
      logic s;
      start();
      for (int i = 0; i < 9; i++) begin
         clock_bit(1'b0, s);
      end
      start();
      stop();
   endtask
endmodule

// ### i2c_wiper_slave_bench.sv
// Self-checking bench for the serial wiper slave
module i2c_wiper_slave_bench;
   timeunit 1ns;
   timeprecision 1ps;

   logic ref_clk;
   logic rst_b;
   logic scl_low;
   logic sda_low;
   logic scl_line;
   logic sda_line;
   logic scl_drv;
   logic scl_oe;
   logic sda_drv;
   logic sda_oe;
   logic [6:0] wiper;
   logic stretch_seen;
   int bad_count;
   int num_checks;

   // Open-drain lines with pull-ups
   assign scl_line = !(scl_low || (scl_oe && !scl_drv));
   assign sda_line = !(sda_low || (sda_oe && !sda_drv));

   i2c_wiper_slave #(.SPIKE_CYC(1)) i2c_wiper_slave_i (
      .ref_clk_in(ref_clk),
      .rst_b_in(rst_b),
      .scl_in(scl_line),
      .sda_in(sda_line),
      .scl_out_out(scl_drv),
      .scl_oe_out(scl_oe),
      .sda_out_out(sda_drv),
      .sda_oe_out(sda_oe),
      .wiper_out(wiper)
   );

   i2c_master_model i2c_master_model_i (
      .clk_in(ref_clk),
      .sda_in(sda_line),
      .scl_low_out(scl_low),
      .sda_low_out(sda_low)
   );

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Slave may only move the data line while the clock is low
   always @(sda_oe) begin
      if (rst_b === 1'b1) check("sda_move_scl", {7'h00, scl_line}, 8'h00);
   end

   always @(posedge ref_clk) begin
      if (rst_b === 1'b1 && scl_oe !== 1'b0) stretch_seen <= 1'b1;
   end

   task automatic addr(input logic [7:0] a, input logic [7:0] exp_ack);
      logic ack;
      i2c_master_model_i.start();
      i2c_master_model_i.put_byte(a, ack);
      check("addr_ack", {7'h00, ack}, exp_ack);
   endtask

   task automatic wr(input logic [7:0] b);
      logic ack;
      addr(8'h5E, 8'h01);
      i2c_master_model_i.put_byte(b, ack);
      check("data_ack", {7'h00, ack}, 8'h01);
      check("sda_drive_level", {7'h00, sda_drv}, 8'h00);
      i2c_master_model_i.stop();
      check("wiper", {1'b0, wiper}, {1'b0, b[6:0]});
   endtask

   task automatic t_reset_value();
      check("wiper_reset", {1'b0, wiper}, 8'h3F);
   endtask

   task automatic t_single_write();
      wr(8'hD5);
   endtask

   task automatic t_multi_write();
      logic ack;
      logic [7:0] vals [3] = '{8'h12, 8'hFF, 8'hAD};
      addr(8'h5E, 8'h01);
      foreach (vals[i]) begin
         i2c_master_model_i.put_byte(vals[i], ack);
         i2c_master_model_i.wait_cyc(3);
         check("multi_ack", {7'h00, ack}, 8'h01);
         check("multi_wiper", {1'b0, wiper}, {1'b0, vals[i][6:0]});
      end
      i2c_master_model_i.stop();
   endtask

   task automatic t_read();
      logic [7:0] d;
      addr(8'h5F, 8'h01);
      i2c_master_model_i.get_byte(8'h00, 1'b1, d);
      check("read_first", d, 8'h2D);
      i2c_master_model_i.get_byte(8'h00, 1'b0, d);
      check("read_second", d, 8'h2D);
      i2c_master_model_i.stop();
      check("read_release", {7'h00, sda_oe}, 8'h00);
   endtask

   task automatic t_bad_addr();
      logic ack;
      logic [7:0] bad [4] = '{8'h5C, 8'h00, 8'h1E, 8'hDE};
      foreach (bad[i]) begin
         addr(bad[i], 8'h00);
         i2c_master_model_i.put_byte(8'h11, ack);
         check("ignored_ack", {7'h00, ack}, 8'h00);
         i2c_master_model_i.stop();
         check("ignored_wiper", {1'b0, wiper}, 8'h2D);
      end
   endtask

   task automatic t_abort();
      logic ack;
      addr(8'h5E, 8'h01);
      i2c_master_model_i.put_bits(8'hA0, 4);
      i2c_master_model_i.stop();
      check("abort_stop", {1'b0, wiper}, 8'h2D);
      addr(8'h5E, 8'h01);
      i2c_master_model_i.put_bits(8'h40, 7);
      addr(8'h5E, 8'h01);
      i2c_master_model_i.put_byte(8'h33, ack);
      i2c_master_model_i.stop();
      check("abort_restart", {1'b0, wiper}, 8'h33);
   endtask

   // Master pulls a slave one low; the slave must drop out of the read
   task automatic t_collision();
      logic [7:0] d;
      wr(8'h60);
      addr(8'h5F, 8'h01);
      i2c_master_model_i.get_byte(8'h40, 1'b0, d);
      check("collision_byte", d, 8'h3F);
      i2c_master_model_i.stop();
      check("collision_wiper", {1'b0, wiper}, 8'h60);
   endtask

   // Recovery while the slave is driving a zero of a read byte
   task automatic t_recovery();
      addr(8'h5F, 8'h01);
      i2c_master_model_i.recover();
      check("recover_release", {7'h00, sda_oe}, 8'h00);
      wr(8'h44);
      check("no_stretch", {7'h00, stretch_seen}, 8'h00);
   endtask

   initial begin
      bad_count = 0;
      num_checks = 0;
      stretch_seen = 1'b0;
      rst_b = 1'b0;
      repeat (20) @(negedge ref_clk);
      rst_b = 1'b1;
      @(negedge ref_clk);
      t_reset_value();
      t_single_write();
      t_multi_write();
      t_read();
      t_bad_addr();
      t_abort();
      t_collision();
      t_recovery();
      results();
   end

   // Whole run needs about 2600 cycles
   initial begin
      repeat (30000) @(posedge ref_clk);
      bad_count++;
      results();
   end
endmodule
